// ===== core/grar_pkg.sv
`default_nettype none
package grar_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int          ID_W          = 29;
  localparam int          GRP_W         = 17;
  localparam int          DATA_W        = 64;
  localparam logic [3:0]  FRAME_DLC     = 4'h8;
  localparam logic [2:0]  PRIO_DEFAULT  = 3'h6;
  localparam logic [7:0]  HI_REQUEST    = 8'hEA;
  localparam logic [7:0]  HI_ACK        = 8'hE8;
  localparam logic [7:0]  ADDR_GLOBAL   = 8'hFF;
  localparam logic [7:0]  FILL_BYTE     = 8'hFF;

  // ----------------------------------------------------------------
  // Acknowledgement codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  ACK_CODE_OK   = 8'h00;
  localparam logic [7:0]  CMD_CODE_MIN  = 8'h80;
  localparam logic [7:0]  CMD_CODE_MAX  = 8'hFA;
  localparam logic [7:0]  INST_SINGLE   = 8'hFF;

  // ----------------------------------------------------------------
  // Sentinel codes of the standard data types
  // ----------------------------------------------------------------
  localparam logic [1:0]  FLAG_OFF      = 2'h0;
  localparam logic [1:0]  FLAG_ON       = 2'h1;
  localparam logic [1:0]  FLAG_ERROR    = 2'h2;
  localparam logic [1:0]  FLAG_NA       = 2'h3;
  localparam logic [7:0]  U8_MAX        = 8'hFC;
  localparam logic [7:0]  U8_RESERVED   = 8'hFD;
  localparam logic [7:0]  U8_OOR        = 8'hFE;
  localparam logic [7:0]  U8_NA         = 8'hFF;
  localparam logic [15:0] U16_MAX       = 16'hFFFC;
  localparam logic [15:0] U16_RESERVED  = 16'hFFFD;
  localparam logic [15:0] U16_OOR       = 16'hFFFE;
  localparam logic [15:0] U16_NA        = 16'hFFFF;
  localparam logic [31:0] U32_MAX       = 32'hFFFFFFFC;
  localparam logic [31:0] U32_RESERVED  = 32'hFFFFFFFD;
  localparam logic [31:0] U32_OOR       = 32'hFFFFFFFE;
  localparam logic [31:0] U32_NA        = 32'hFFFFFFFF;
  localparam logic [31:0] I32_MAX       = 32'h7FFFFFFC;
  localparam logic [31:0] I32_RESERVED  = 32'h7FFFFFFD;
  localparam logic [31:0] I32_OOR       = 32'h7FFFFFFE;
  localparam logic [31:0] I32_NA        = 32'h7FFFFFFF;
  localparam logic [7:0]  CHAR_RESERVED = 8'h00;
  localparam logic [7:0]  CHAR_MAX      = 8'hFD;
  localparam logic [7:0]  CHAR_OOR      = 8'hFE;
  localparam logic [7:0]  CHAR_NA       = 8'hFF;
  localparam logic [31:0] F32_RESERVED  = 32'h7FFFFFFD;
  localparam logic [31:0] F32_OOR       = 32'h7FFFFFFE;
  localparam logic [31:0] F32_NA        = 32'h7FFFFFFF;
  localparam logic [63:0] F64_RESERVED  = 64'h7FFFFFFFFFFFFFFD;
  localparam logic [63:0] F64_OOR       = 64'h7FFFFFFFFFFFFFFE;
  localparam logic [63:0] F64_NA        = 64'h7FFFFFFFFFFFFFFF;

  // ----------------------------------------------------------------
  // Controller register map (word index, paddr[4:2])
  // ----------------------------------------------------------------
  localparam logic [2:0]  REG_CTRL      = 3'h0;
  localparam logic [2:0]  REG_INJ_ID    = 3'h1;
  localparam logic [2:0]  REG_INJ_LO    = 3'h2;
  localparam logic [2:0]  REG_INJ_HI    = 3'h3;
  localparam logic [2:0]  REG_CAP_ID    = 3'h4;
  localparam logic [2:0]  REG_CAP_LO    = 3'h5;
  localparam logic [2:0]  REG_CAP_HI    = 3'h6;
  localparam logic [2:0]  REG_STATUS    = 3'h7;
  localparam int          CTRL_INJECT   = 0;
  localparam int          CTRL_RELEASE  = 1;
  localparam int          CTRL_ADDR_LSB = 8;
  localparam logic [7:0]  HOST_ADDR_RST = 8'hFE;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [ID_W-1:0] make_id(input logic [2:0] prio,
      input logic [GRP_W-1:0] grp, input logic [7:0] src);
    make_id = {prio, 1'b0, grp, src};
  endfunction

  function automatic logic [7:0] sat_u8(input logic [8:0] v);
    sat_u8 = (v > {1'b0, U8_MAX}) ? U8_OOR : v[7:0];
  endfunction

endpackage
`default_nettype wire

// ===== core/grar_can_if.sv
`timescale 1ns/100ps
`default_nettype none
interface grar_can_if;
  logic                          rx_valid;
  logic                          rx_ready;
  logic [grar_pkg::ID_W-1:0]     rx_id;
  logic [grar_pkg::DATA_W-1:0]   rx_data;
  logic                          tx_valid;
  logic                          tx_ready;
  logic [grar_pkg::ID_W-1:0]     tx_id;
  logic [grar_pkg::DATA_W-1:0]   tx_data;

  modport dev (input rx_valid, rx_id, rx_data, tx_ready,
               output rx_ready, tx_valid, tx_id, tx_data);
  modport ctl (output rx_valid, rx_id, rx_data, tx_ready,
               input rx_ready, tx_valid, tx_id, tx_data);
endinterface
`default_nettype wire

// ===== core/grar_device.sv
// Behaviour
// - Text MSB first, other numbers LSB first.
// - Byte n holds bits 8n+7..8n, MSB first.
// - Flag codes: off, on, error, unavailable.
// - uint8 sentinels 253 reserved, 254, 255.
// - uint16 sentinels 65533, 65534, 65535.
// - uint32 top three codes are sentinels.
// - int32 top three codes are sentinels.
// - char 0 reserved, 254 range, 255 unavailable.
// - Float sentinels 7F..FD, 7F..FE, 7F..FF.
// - Always send whole group, unavailable filled.
// - Broadcast information normally at priority six.
// - Request: high EAh, priority 6, 3 bytes.
// - Supported request: send group, no ack.
// - Unsupported direct request NAKs; global silent.
// - Acked command gets ACK or coded NAK.
// - Unsupported sub-command: no acknowledgement at all.
// - Ack: high E8h, priority 6, to sender.
// - Receivers accept legacy global acknowledgements too.
// - Ack bytes: code, instance, bank, group.
// - Code zero means success, nonzero failure.
// - Command-specific failure codes span 128 to 250.
// - Extended data frames, length eight, never remote.
// - Identifier: priority, zero, group, source address.
`timescale 1ns/100ps
`default_nettype none
module grar_device #(
  parameter int          DEPTH     = 4,
  parameter logic [7:0]  NAK_UNSUP = 8'h01,
  parameter logic [7:0]  NAK_FAIL  = 8'h01
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          arst_n,
  input  wire logic                          ce,
  // Node identity
  input  wire logic [7:0]                    node_addr,
  input  wire logic [7:0]                    node_inst,
  input  wire logic [3:0]                    node_bank,
  // Link to the CAN controller
  grar_can_if.dev                            can,
  // Group supply
  output logic                               grp_req,
  output logic [grar_pkg::GRP_W-1:0]         grp_num,
  input  wire logic                          grp_rsp_valid,
  input  wire logic                          grp_rsp_supported,
  input  wire logic [7:0]                    grp_rsp_avail,
  input  wire logic [grar_pkg::DATA_W-1:0]   grp_rsp_data,
  // Command handler
  output logic                               cmd_valid,
  output logic [grar_pkg::GRP_W-1:0]         cmd_group,
  output logic [7:0]                         cmd_src,
  output logic [grar_pkg::DATA_W-1:0]        cmd_data,
  input  wire logic                          cmd_done,
  input  wire logic                          cmd_ack,
  input  wire logic                          cmd_ok,
  input  wire logic [7:0]                    cmd_code
);

  localparam int PW = $clog2(DEPTH);

  typedef enum logic [1:0] {ST_IDLE, ST_GRP, ST_CMD, ST_PUSH} grar_state_e;

  // ----------------------------------------------------------------
  // Frame builders
  // ----------------------------------------------------------------
  // Unavailable bytes are forced to all ones, the not-available code of
  // unsigned and character items; signed and float items must arrive
  // already coded, since a byte mask cannot tell their type.
  function automatic logic [63:0] na_fill(input logic [63:0] d,
                                          input logic [7:0]  avail);
    na_fill = d;
    for (int i = 0; i < 8; i++) begin
      if (!avail[i]) begin
        na_fill[8*i +: 8] = grar_pkg::FILL_BYTE;
      end
    end
  endfunction

  function automatic logic [63:0] ack_data(input logic [7:0] code,
      input logic [7:0] inst, input logic [3:0] bank,
      input logic [grar_pkg::GRP_W-1:0] grp);
    logic [23:0] g;
    g = {7'h00, grp};
    ack_data = {g[23:16], g[15:8], g[7:0],
                grar_pkg::FILL_BYTE, grar_pkg::FILL_BYTE,
                {4'hF, bank}, inst, code};
  endfunction

  // ----------------------------------------------------------------
  // Receive decode
  // ----------------------------------------------------------------
  wire logic [8:0] rx_hi  = can.rx_id[24:16];
  wire logic [7:0] rx_lo  = can.rx_id[15:8];
  wire logic [7:0] rx_src = can.rx_id[7:0];
  wire logic       to_me  = rx_lo == node_addr;
  wire logic       to_all = rx_lo == grar_pkg::ADDR_GLOBAL;
  wire logic       hi_req = rx_hi == {1'b0, grar_pkg::HI_REQUEST};
  wire logic       hi_ack = rx_hi == {1'b0, grar_pkg::HI_ACK};
  wire logic       is_req = hi_req && (to_me || to_all);
  wire logic       is_cmd = !hi_req && !hi_ack && rx_src != node_addr;
  wire logic       take   = can.rx_valid && can.rx_ready;

  grar_state_e                     state_q;
  logic                            rx_ready_q;
  logic                            direct_q;
  logic [7:0]                      src_q;
  logic [grar_pkg::ID_W-1:0]       pend_id_q;
  logic [grar_pkg::DATA_W-1:0]     pend_data_q;
  logic [grar_pkg::ID_W-1:0]       qid   [DEPTH];
  logic [grar_pkg::DATA_W-1:0]     qdat  [DEPTH];
  logic [PW-1:0]                   wp_q;
  logic [PW-1:0]                   rp_q;
  logic [PW:0]                     cnt_q;
  logic                            tx_valid_q;
  logic [grar_pkg::ID_W-1:0]       tx_id_q;
  logic [grar_pkg::DATA_W-1:0]     tx_data_q;

  wire logic full = cnt_q == (PW+1)'(DEPTH);
  wire logic enq  = ce && state_q == ST_PUSH && !full;
  wire logic pop  = ce && cnt_q != '0 && (!tx_valid_q || can.tx_ready);

  // A NAK never leaves with code zero even if the handler forgets one.
  wire logic [7:0] cmd_res = cmd_ok ? grar_pkg::ACK_CODE_OK
                           : (cmd_code == grar_pkg::ACK_CODE_OK)
                           ? NAK_FAIL : cmd_code;
  wire logic [grar_pkg::GRP_W-1:0] ack_grp = {1'b0, grar_pkg::HI_ACK, src_q};
  wire logic [grar_pkg::ID_W-1:0]  ack_id  =
    grar_pkg::make_id(grar_pkg::PRIO_DEFAULT, ack_grp, node_addr);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q     <= ST_IDLE;
      rx_ready_q  <= 1'b0;
      direct_q    <= 1'b0;
      src_q       <= 8'h00;
      pend_id_q   <= '0;
      pend_data_q <= '0;
      grp_req     <= 1'b0;
      grp_num     <= '0;
      cmd_valid   <= 1'b0;
      cmd_group   <= '0;
      cmd_src     <= 8'h00;
      cmd_data    <= '0;
    end else if (ce) begin
      grp_req   <= 1'b0;
      cmd_valid <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          rx_ready_q <= !take;
          if (take) begin
            src_q    <= rx_src;
            direct_q <= to_me;
            if (is_req) begin
              grp_req <= 1'b1;
              grp_num <= can.rx_data[grar_pkg::GRP_W-1:0];
              state_q <= ST_GRP;
            end else if (is_cmd) begin
              cmd_valid <= 1'b1;
              cmd_group <= can.rx_id[24:8];
              cmd_src   <= rx_src;
              cmd_data  <= can.rx_data;
              state_q   <= ST_CMD;
            end else begin
              rx_ready_q <= 1'b1;
            end
          end
        end
        ST_GRP: begin
          if (grp_rsp_valid) begin
            if (grp_rsp_supported) begin
              pend_id_q   <= grar_pkg::make_id(grar_pkg::PRIO_DEFAULT,
                               grp_num, node_addr);
              pend_data_q <= na_fill(grp_rsp_data, grp_rsp_avail);
              state_q     <= ST_PUSH;
            end else if (direct_q) begin
              pend_id_q   <= ack_id;
              pend_data_q <= ack_data(NAK_UNSUP, node_inst, node_bank,
                                      grp_num);
              state_q     <= ST_PUSH;
            end else begin
              rx_ready_q <= 1'b1;
              state_q    <= ST_IDLE;
            end
          end
        end
        ST_CMD: begin
          if (cmd_done) begin
            if (cmd_ack) begin
              pend_id_q   <= ack_id;
              pend_data_q <= ack_data(cmd_res, node_inst, node_bank,
                                      cmd_group);
              state_q     <= ST_PUSH;
            end else begin
              rx_ready_q <= 1'b1;
              state_q    <= ST_IDLE;
            end
          end
        end
        ST_PUSH: begin
          if (!full) begin
            rx_ready_q <= 1'b1;
            state_q    <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Reply queue and transmit stage
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (enq) begin
      qid[wp_q]  <= pend_id_q;
      qdat[wp_q] <= pend_data_q;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (enq) begin
        wp_q <= (wp_q == PW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == PW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + {{PW{1'b0}}, enq} - {{PW{1'b0}}, pop};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_valid_q <= 1'b0;
      tx_id_q    <= '0;
      tx_data_q  <= '0;
    end else if (ce) begin
      if (pop) begin
        tx_valid_q <= 1'b1;
        tx_id_q    <= qid[rp_q];
        tx_data_q  <= qdat[rp_q];
      end else if (can.tx_ready) begin
        tx_valid_q <= 1'b0;
      end
    end
  end

  assign can.rx_ready = rx_ready_q;
  assign can.tx_valid = tx_valid_q;
  assign can.tx_id    = tx_id_q;
  assign can.tx_data  = tx_data_q;

endmodule // grar_device
`default_nettype wire

// ===== core/grar_host.sv
`timescale 1ns/100ps
`default_nettype none
module grar_host #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire logic                 ce,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic                      pslverr,
  output logic [31:0]               prdata,
  // Link to the device
  grar_can_if.ctl                   can
);

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire logic [2:0] idx    = paddr[4:2];
  wire logic       hit    = paddr[ADDR_W-1:5] == '0 && paddr[1:0] == 2'h0;
  wire logic       access = psel && penable && !pready;
  wire logic       wr_fire = ce && psel && penable && pready && pwrite && hit;
  wire logic       wr_ctrl = wr_fire && idx == grar_pkg::REG_CTRL;

  logic [7:0]                    addr_q;
  logic                          rx_valid_q;
  logic [grar_pkg::ID_W-1:0]     inj_id_q;
  logic [grar_pkg::DATA_W-1:0]   inj_data_q;
  logic                          cap_full_q;
  logic                          tx_ready_q;
  logic [grar_pkg::ID_W-1:0]     cap_id_q;
  logic [grar_pkg::DATA_W-1:0]   cap_data_q;

  wire logic cap_set = ce && can.tx_valid && tx_ready_q;
  wire logic cap_clr = wr_ctrl && pwdata[grar_pkg::CTRL_RELEASE];
  // A frame landing in the cycle of a release keeps the slot full.
  wire logic cap_full_d = cap_set || (cap_full_q && !cap_clr);

  // Legacy nodes may address acknowledgements globally.
  wire logic cap_ack = cap_id_q[24:16] == {1'b0, grar_pkg::HI_ACK} &&
                       (cap_id_q[15:8] == addr_q ||
                        cap_id_q[15:8] == grar_pkg::ADDR_GLOBAL);
  wire logic cap_nak = cap_ack && cap_data_q[7:0] != grar_pkg::ACK_CODE_OK;

  logic [31:0] rd_mux;
  always_comb begin
    case (idx)
      grar_pkg::REG_CTRL:   rd_mux = {16'h0000, addr_q, 8'h00};
      grar_pkg::REG_INJ_ID: rd_mux = {3'h0, inj_id_q};
      grar_pkg::REG_INJ_LO: rd_mux = inj_data_q[31:0];
      grar_pkg::REG_INJ_HI: rd_mux = inj_data_q[63:32];
      grar_pkg::REG_CAP_ID: rd_mux = {3'h0, cap_id_q};
      grar_pkg::REG_CAP_LO: rd_mux = cap_data_q[31:0];
      grar_pkg::REG_CAP_HI: rd_mux = cap_data_q[63:32];
      default:              rd_mux = {28'h0000000, cap_nak, cap_ack,
                                      rx_valid_q, cap_full_q};
    endcase
  end

  // ----------------------------------------------------------------
  // APB answer: one wait state, read data registered
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (ce) begin
      pready  <= access;
      pslverr <= access && !hit;
      if (access && !pwrite) begin
        prdata <= hit ? rd_mux : 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame injection and capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_q     <= grar_pkg::HOST_ADDR_RST;
      rx_valid_q <= 1'b0;
      inj_id_q   <= '0;
      inj_data_q <= '0;
    end else if (ce) begin
      if (wr_ctrl) begin
        addr_q <= pwdata[grar_pkg::CTRL_ADDR_LSB +: 8];
      end
      if (wr_fire && idx == grar_pkg::REG_INJ_ID) begin
        inj_id_q <= pwdata[grar_pkg::ID_W-1:0];
      end
      if (wr_fire && idx == grar_pkg::REG_INJ_LO) begin
        inj_data_q[31:0] <= pwdata;
      end
      if (wr_fire && idx == grar_pkg::REG_INJ_HI) begin
        inj_data_q[63:32] <= pwdata;
      end
      if (rx_valid_q && can.rx_ready) begin
        rx_valid_q <= 1'b0;
      end else if (wr_ctrl && pwdata[grar_pkg::CTRL_INJECT]) begin
        rx_valid_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_full_q <= 1'b0;
      tx_ready_q <= 1'b0;
      cap_id_q   <= '0;
      cap_data_q <= '0;
    end else if (ce) begin
      cap_full_q <= cap_full_d;
      tx_ready_q <= !cap_full_d;
      if (cap_set) begin
        cap_id_q   <= can.tx_id;
        cap_data_q <= can.tx_data;
      end
    end
  end

  assign can.rx_valid = rx_valid_q;
  assign can.rx_id    = inj_id_q;
  assign can.rx_data  = inj_data_q;
  assign can.tx_ready = tx_ready_q;

endmodule // grar_host
`default_nettype wire

// ===== tb/grar_link_chk.sv
`timescale 1ns/100ps
`default_nettype none
module grar_link_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // Link signals
  input wire logic        rx_valid,
  input wire logic        rx_ready,
  input wire logic [28:0] rx_id,
  input wire logic [63:0] rx_data,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [28:0] tx_id,
  input wire logic [63:0] tx_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // An acknowledgement is a reply whose high group part is E8h.
  wire ack = tx_valid && tx_id[24:16] == 9'h0E8;

  prio_six_a: assert property (tx_valid |-> tx_id[28:26] == 3'h6)
    else $error("reply priority not six");
  id_zero_a: assert property (tx_valid |-> !tx_id[25])
    else $error("identifier bit 25 set");
  tx_hold_a: assert property (tx_valid && !tx_ready
    |=> tx_valid && $stable(tx_id) && $stable(tx_data))
    else $error("reply changed while stalled");
  rx_hold_a: assert property (rx_valid && !rx_ready
    |=> rx_valid && $stable(rx_id) && $stable(rx_data))
    else $error("offered frame changed before taken");
  rx_take_a: assert property (rx_valid && rx_ready
    && rx_id[24:8] == 17'h0EAFF |=> !rx_ready)
    else $error("device ready right after global request");
  ack_fill_a: assert property (ack |-> tx_data[39:20] == 20'hFFFFF)
    else $error("ack filler bytes wrong");
  ack_grp_a: assert property (ack |-> tx_data[63:57] == 7'h00)
    else $error("ack group wider than 17 bits");
  rst_idle_a: assert property ($rose(arst_n)
    |-> !tx_valid && !rx_valid)
    else $error("link busy out of reset");

  cover property (ack && tx_ready);
  cover property (tx_valid && !tx_ready ##1 tx_valid);
  cover property (rx_valid && rx_ready);
endmodule // grar_link_chk
`default_nettype wire

// ===== tb/group_request_ack_responder_bench.sv
`timescale 1ns/100ps
`default_nettype none
module group_request_ack_responder_bench;
  localparam logic [7:0] NODE = 8'h21;
  localparam logic [7:0] HOST = grar_pkg::HOST_ADDR_RST;
  logic clk = 0, arst_n = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, e, grp_req, cmd_valid, is_g = 0;
  logic grp_rsp_valid = 0, grp_rsp_supported = 0, cmd_done = 0;
  logic cmd_ack = 0, cmd_ok = 0;
  logic [7:0] node_addr = NODE, node_inst = 0, grp_rsp_avail = 0;
  logic [7:0] cmd_code = 0, cmd_src, st, c;
  logic [3:0] node_bank = 0;
  logic [16:0] grp_num, cmd_group, g;
  logic [28:0] id, xi;
  logic [63:0] grp_rsp_data = 0, cmd_data, dat, xd;
  int errors = 0, comparisons = 0, seed = 32'hC1B5;

  grar_can_if can_link ();
  grar_device #(.DEPTH(4)) grar_device_inst (.clk, .arst_n, .ce,
    .node_addr, .node_inst, .node_bank, .can(can_link), .grp_req,
    .grp_num, .grp_rsp_valid, .grp_rsp_supported, .grp_rsp_avail,
    .grp_rsp_data, .cmd_valid, .cmd_group, .cmd_src, .cmd_data,
    .cmd_done, .cmd_ack, .cmd_ok, .cmd_code);
  grar_host grar_host_inst (.clk, .arst_n, .ce, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .can(can_link));
  grar_link_chk grar_link_chk_inst (.clk, .arst_n,
    .rx_valid(can_link.rx_valid), .rx_ready(can_link.rx_ready),
    .rx_id(can_link.rx_id), .rx_data(can_link.rx_data),
    .tx_valid(can_link.tx_valid), .tx_ready(can_link.tx_ready),
    .tx_id(can_link.tx_id), .tx_data(can_link.tx_data));

  always #20 clk = ~clk;

  // Application side answers each request or command after 0 to 3 cycles.
  always @(posedge clk) begin
    if (grp_req === 1'b1 || cmd_valid === 1'b1) begin
      is_g = grp_req;
      if (is_g) chk(grp_num, xd[16:0]);
      else chk({cmd_src, cmd_group}, {xi[7:0], xi[24:8]});
      if (!is_g) chk(cmd_data, xd);
      repeat ($unsigned($random(seed)) % 4) @(posedge clk);
      grp_rsp_valid <= is_g;
      cmd_done <= !is_g;
      @(posedge clk);
      grp_rsp_valid <= 1'b0;
      cmd_done <= 1'b0;
    end
  end

  function automatic logic [28:0] fid(logic [16:0] gr, logic [7:0] s);
    return {3'h6, 1'b0, gr, s};
  endfunction
  function automatic logic [63:0] fill(logic [63:0] d, logic [7:0] av);
    for (int i = 0; i < 8; i++) if (!av[i]) d[8*i+:8] = 8'hFF;
    return d;
  endfunction
  function automatic logic [63:0] fack(logic [7:0] k, logic [16:0] gr);
    return {7'h00, gr, 16'hFFFF, 4'hF, node_bank, node_inst, k};
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic inject(input logic [28:0] i, input logic [63:0] d);
    do apb(0, 12'h01C, 0); while (r[1] !== 1'b0);
    apb(1, 12'h004, {3'h0, i});
    apb(1, 12'h008, d[31:0]);
    apb(1, 12'h00C, d[63:32]);
    xi = i;
    xd = d;
    apb(1, 12'h000, {16'h0000, HOST, 8'h01});
  endtask
  task automatic reply;
    do apb(0, 12'h01C, 0); while (r[0] !== 1'b1);
    st = r[7:0];
    apb(0, 12'h010, 0);
    id = r[28:0];
    apb(0, 12'h014, 0);
    dat[31:0] = r;
    apb(0, 12'h018, 0);
    dat[63:32] = r;
    apb(1, 12'h000, {16'h0000, HOST, 8'h02});
  endtask
  task automatic request(input logic [7:0] dst, input logic [16:0] gr,
                         input logic sup);
    grp_rsp_supported <= sup;
    inject({3'h6, 2'b00, 8'hEA, dst, HOST}, {40'hFF_FFFF_FFFF, 7'h0, gr});
  endtask
  task automatic resp(input logic [16:0] gr);
    reply;
    chk(id, fid(gr, NODE));
    chk(dat, fill(grp_rsp_data, grp_rsp_avail));
  endtask
  task automatic ackd(input logic [7:0] k, input logic [16:0] gr);
    reply;
    chk(id, fid({1'b0, 8'hE8, HOST}, NODE));
    chk(dat, fack(k, gr));
    chk(st[3:2], {k != 8'h00, 1'b1});
  endtask
  task automatic silent;
    repeat (40) @(posedge clk);
    apb(0, 12'h01C, 0);
    chk(r[0], 1'b0);
  endtask
  task automatic final_report;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (50000) @(posedge clk);
    errors++;
    final_report;
  end

  initial begin
    node_inst <= 8'($random(seed));
    node_bank <= 4'($random(seed));
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    apb(0, 12'h000, 0);
    chk(r, {16'h0000, HOST, 8'h00});
    apb(0, 12'h01C, 0);
    chk(r, 32'h0);
    apb(0, 12'h020, 0);
    chk({e, r}, {1'b1, 32'h0});
    for (int k = 0; k < 6; k++) begin
      g = {1'b1, 16'($random(seed))};
      grp_rsp_avail <= (k == 0) ? 8'h00 : 8'($random(seed));
      grp_rsp_data <= {$random(seed), $random(seed)};
      request(k[0] ? NODE : 8'hFF, g, 1'b1);
      resp(g);
    end
    request(NODE, g, 1'b0);
    ackd(8'h01, g);
    request(8'hFF, g, 1'b0);
    silent;
    request(8'h33, g, 1'b1);
    silent;
    for (int k = 0; k < 8; k++) begin
      g = {5'h1F, 12'($random(seed))};
      c = (k == 2) ? 8'h80 : (k == 6) ? 8'hFA :
          8'h80 + 8'($unsigned($random(seed)) % 123);
      cmd_ack <= k % 4 != 3;
      cmd_ok <= k % 4 == 0;
      cmd_code <= (k % 4 == 2) ? c : 8'h00;
      inject({3'h3, 1'b0, g, HOST}, {$random(seed), $random(seed)});
      if (k % 4 == 3) silent;
      else ackd((k % 4 == 0) ? 8'h00 : (k % 4 == 1) ? 8'h01 : c, g);
    end
    for (int k = 0; k < 3; k++) request(NODE, 17'h1C000 + 17'(k), 1'b1);
    // Freeze both ends with a frame offered and replies waiting.
    ce <= 1'b0;
    repeat (6) @(posedge clk);
    ce <= 1'b1;
    for (int k = 0; k < 3; k++) resp(17'h1C000 + 17'(k));
    final_report;
  end
endmodule // group_request_ack_responder_bench
`default_nettype wire
